// [verilog/geom_id_pkg.sv]
// Constants for the geometry and identify command handler.
// Assumes one 25 MHz clock; task-file offsets are the printed port addresses.
package geom_id_pkg;
	// Task-file register addresses
	localparam logic [9:0] ADDR_ERROR_FEATURE = 10'h1F1;
	localparam logic [9:0] ADDR_TRANSFER_COUNT = 10'h1F2;
	localparam logic [9:0] ADDR_SECTOR_INDEX = 10'h1F3;
	localparam logic [9:0] ADDR_CYL_LOW = 10'h1F4;
	localparam logic [9:0] ADDR_CYL_HIGH = 10'h1F5;
	localparam logic [9:0] ADDR_DRIVE_HEAD = 10'h1F6;
	localparam logic [9:0] ADDR_CMD_STATE = 10'h1F7;
	localparam logic [9:0] ADDR_DATA = 10'h1F0;
	// Command codes
	localparam logic [7:0] CMD_SET_GEOMETRY = 8'h91;
	localparam logic [7:0] CMD_IDENTIFY = 8'hEC;
	// Status bits
	localparam int ST_BUSY = 7;
	localparam int ST_READY = 6;
	localparam int ST_SEEK_DONE = 4;
	localparam int ST_DATA_REQ = 3;
	localparam int ST_ERROR = 0;
	// Error bits
	localparam logic [7:0] ERR_ABORTED = 8'h04;
	localparam logic [7:0] ERR_NONE = 8'h00;
	// Field positions in drive_head_select
	localparam int DH_LBA_BIT = 6;
	localparam int DH_SELECT_BIT = 4;
	// Identify block layout
	localparam int ID_WORDS = 256;
	localparam logic [7:0] ID_LAST_WORD = 8'hFF;
	// Defaults and reset values
	localparam logic [15:0] DEF_CYLINDERS = 16'h3FFF;
	localparam logic [15:0] DEF_HEADS = 16'h0010;
	localparam logic [7:0] DEF_SECTORS = 8'h3F;
	localparam logic [3:0] DEF_MAX_HEAD = 4'hF;
	localparam logic [7:0] RESET_STATE = 8'h50;
	// Fixed identify words
	localparam logic [15:0] W0_CONFIG = 16'h045A;
	localparam logic [15:0] W6_SECTORS = 16'h003F;
	localparam logic [15:0] W21_BUFFER = 16'h1000;
	localparam logic [15:0] W22_CHECK_BYTES = 16'h0004;
	localparam logic [15:0] W47_MULTI = 16'h8010;
	localparam logic [15:0] W49_CAPS = 16'h0B00;
	localparam logic [15:0] W51_PIO = 16'h0200;
	localparam logic [15:0] W53_VALID = 16'h0007;
	localparam logic [15:0] ASCII_BLANKS = 16'h2020;
	// Processing time before completion
	localparam int WORK_NS = 400;
	localparam int CLK_NS = 40;
	localparam int WORK_CYCLES = (WORK_NS + CLK_NS - 1) / CLK_NS;
endpackage

// [verilog/pin_sync.sv]
// Three-stage synchroniser for one level from outside the clock domain.
// Output changes only once the second and third stages agree.
`timescale 1ns/1ps
module pin_sync (
	// Clock and reset
	input wire logic clk_sys,
	input wire logic sys_rst,
	// Signal
	input wire logic pin_in,
	output logic pin_out
);
	logic s1_r;
	logic s2_r;
	logic s3_r;

	always_ff @(posedge clk_sys) begin
		if (sys_rst) begin
			s1_r <= 1'b0;
			s2_r <= 1'b0;
			s3_r <= 1'b0;
		end else begin
			s1_r <= pin_in;
			s2_r <= s1_r;
			s3_r <= s2_r;
		end
	end

	always_ff @(posedge clk_sys) begin
		if (sys_rst)
			pin_out <= 1'b0;
		else if (s2_r == s3_r)
			pin_out <= s3_r;
	end
endmodule // pin_sync

// [verilog/identify_rom.sv]
// Builds one word of the identify parameter block from its index.
// Pure combinational; current-geometry words 54 and 55 come in from the caller.
`timescale 1ns/1ps
module identify_rom
	import geom_id_pkg::*;
(
	// Lookup
	input wire logic [7:0] word_idx,
	input wire logic [15:0] cur_cylinders,
	input wire logic [15:0] cur_heads,
	output logic [15:0] word_val
);
	always_comb begin
		word_val = 16'h0000;
		case (word_idx)
			8'd0: word_val = W0_CONFIG;
			8'd1: word_val = DEF_CYLINDERS;
			8'd3: word_val = DEF_HEADS;
			8'd6: word_val = W6_SECTORS;
			8'd21: word_val = W21_BUFFER;
			8'd22: word_val = W22_CHECK_BYTES;
			8'd47: word_val = W47_MULTI;
			8'd49: word_val = W49_CAPS;
			8'd51: word_val = W51_PIO;
			8'd53: word_val = W53_VALID;
			8'd54: word_val = cur_cylinders;
			8'd55: word_val = cur_heads;
			default: begin
				// Serial, firmware and model text blank-filled
				if ((word_idx >= 8'd10 && word_idx <= 8'd19) ||
					(word_idx >= 8'd23 && word_idx <= 8'd46))
					word_val = ASCII_BLANKS;
			end
		endcase
	end
endmodule // identify_rom

// [verilog/geom_id_cmds.sv]
// Drive-side handler for the set-geometry and identify commands.
// Host reaches the task file over a plain register port on clk_sys;
// read and write strobes are one-cycle pulses.
// Stored geometry is cleared by por_rst only, never by sys_rst.
// drive_id_pin may change at any time and is synchronised here.
// What this block does
// - Command 0x91 sets sectors per track and highest head number.
// - Geometry command raises busy, stores values, drops busy, interrupts.
// - Zero transfer count aborts the geometry command with an error.
// - Stored geometry survives sys_rst; only por_rst clears it.
// - Geometry command ignores the LBA bit and runs as CHS.
// - Geometry under LBA never widens the default reachable area.
// - Command 0xEC returns a 512-byte parameter block.
// - Identify raises busy and fills the buffer before offering data.
// - With the block buffered, data-request and interrupt are raised.
// - Word 6 reports 0x003F sectors per track.
// - Word 21 reports buffer size 0x1000.
// - Word 22 reports 0x0004 check bytes.
// - Word 47 reports 0x8010 sectors per interrupt.
// - Word 51 reports PIO mode 0x0200.
// - Word 53 reports 0x0007 valid word groups.
// - Word 54 reports the default cylinder count, word 55 the current heads.
// - Serial, firmware and model text in words 10-19, 23-26, 27-46.
`timescale 1ns/1ps
module geom_id_cmds
	import geom_id_pkg::*;
(
	// Clock and reset
	input wire logic clk_sys,
	input wire logic sys_rst,
	// Power-on reset, clears stored geometry only
	input wire logic por_rst,
	// Task-file port
	input wire logic [9:0] reg_addr,
	input wire logic reg_wr,
	input wire logic reg_rd,
	input wire logic [15:0] reg_wdata,
	output logic [15:0] reg_rdata,
	// Drive number of this device
	input wire logic drive_id_pin,
	// Interrupt request to host
	output logic intrq
);
	typedef enum {S_IDLE, S_GEOM, S_FILL, S_DATA} cmd_state_t;
	typedef enum {K_NONE, K_GEOM, K_IDENT, K_BAD} cmd_kind_t;

	cmd_state_t state_r;
	logic [7:0] error_code_r;
	logic [7:0] feature_select_r;
	logic [7:0] transfer_count_r;
	logic [7:0] sector_index_r;
	logic [7:0] cylinder_low_byte_r;
	logic [7:0] cylinder_high_byte_r;
	logic [7:0] drive_head_select_r;
	logic [7:0] drive_state_r;
	logic [7:0] geom_sectors_r;
	logic [3:0] geom_max_head_r;
	logic [7:0] work_cnt_r;
	logic [7:0] fill_idx_r;
	logic [7:0] rd_idx_r;
	logic [15:0] id_buf [ID_WORDS];
	logic [15:0] rom_word;
	logic [15:0] cur_heads;
	logic [15:0] data_out_r;
	logic drive_id;
	logic selected;
	logic wr_cmd;
	logic rd_data;
	logic rd_state;
	logic tf_wr;
	logic cmd_any;
	logic cmd_geom;
	logic cmd_ident;
	logic cmd_bad;
	logic geom_end;
	logic geom_fail;
	logic fill_end;
	logic data_end;
	cmd_kind_t cmd_kind;
	logic [15:0] rd_mux;

	////////////////////////////////////////////////////////////////
	// Decode

	pin_sync u_drive_sync (
		.clk_sys(clk_sys),
		.sys_rst(sys_rst),
		.pin_in(drive_id_pin),
		.pin_out(drive_id)
	);

	assign selected = (drive_head_select_r[DH_SELECT_BIT] == drive_id);
	assign wr_cmd = reg_wr && reg_addr == ADDR_CMD_STATE && selected &&
		!drive_state_r[ST_BUSY];
	assign rd_data = reg_rd && reg_addr == ADDR_DATA && state_r == S_DATA;
	assign rd_state = reg_rd && reg_addr == ADDR_CMD_STATE && selected;
	assign cur_heads = {12'h000, geom_max_head_r} + 16'h0001;

	// Command life cycle events
	assign tf_wr = reg_wr && !drive_state_r[ST_BUSY];
	// Commands only while idle and selected
	assign cmd_any = wr_cmd && state_r == S_IDLE;
	assign geom_end = state_r == S_GEOM && work_cnt_r == 8'd0;
	assign geom_fail = geom_end && transfer_count_r == 8'h00;
	assign fill_end = state_r == S_FILL && fill_idx_r == ID_LAST_WORD;
	assign data_end = rd_data && rd_idx_r == ID_LAST_WORD;

	// Unknown codes abort
	always_comb begin
		cmd_kind = K_NONE;
		if (cmd_any) begin
			case (reg_wdata[7:0])
				CMD_SET_GEOMETRY: cmd_kind = K_GEOM;
				CMD_IDENTIFY: cmd_kind = K_IDENT;
				default: cmd_kind = K_BAD;
			endcase
		end
	end

	assign cmd_geom = cmd_kind == K_GEOM;
	assign cmd_ident = cmd_kind == K_IDENT;
	assign cmd_bad = cmd_kind == K_BAD;

	////////////////////////////////////////////////////////////////
	// Writable task-file registers, ignored while busy

	// Kept but neither read back nor used here; 0x1F1 reads the error register
	always_ff @(posedge clk_sys) begin
		if (sys_rst)
			feature_select_r <= 8'h00;
		else if (tf_wr && reg_addr == ADDR_ERROR_FEATURE)
			feature_select_r <= reg_wdata[7:0];
	end

	// Sectors per track for the geometry command
	always_ff @(posedge clk_sys) begin
		if (sys_rst)
			transfer_count_r <= 8'h01;
		else if (tf_wr && reg_addr == ADDR_TRANSFER_COUNT)
			transfer_count_r <= reg_wdata[7:0];
	end

	always_ff @(posedge clk_sys) begin
		if (sys_rst)
			sector_index_r <= 8'h01;
		else if (tf_wr && reg_addr == ADDR_SECTOR_INDEX)
			sector_index_r <= reg_wdata[7:0];
	end

	always_ff @(posedge clk_sys) begin
		if (sys_rst)
			cylinder_low_byte_r <= 8'h00;
		else if (tf_wr && reg_addr == ADDR_CYL_LOW)
			cylinder_low_byte_r <= reg_wdata[7:0];
	end

	always_ff @(posedge clk_sys) begin
		if (sys_rst)
			cylinder_high_byte_r <= 8'h00;
		else if (tf_wr && reg_addr == ADDR_CYL_HIGH)
			cylinder_high_byte_r <= reg_wdata[7:0];
	end

	// Bit 4 picks the drive, low nibble the head
	always_ff @(posedge clk_sys) begin
		if (sys_rst)
			drive_head_select_r <= 8'h00;
		else if (tf_wr && reg_addr == ADDR_DRIVE_HEAD)
			drive_head_select_r <= reg_wdata[7:0];
	end

	////////////////////////////////////////////////////////////////
	// Stored geometry: only power-on clears it

	always_ff @(posedge clk_sys) begin
		if (por_rst)
			geom_sectors_r <= DEF_SECTORS;
		else if (geom_end && !geom_fail)
			geom_sectors_r <= transfer_count_r;
	end

	// LBA bit not consulted, head taken as CHS
	always_ff @(posedge clk_sys) begin
		if (por_rst)
			geom_max_head_r <= DEF_MAX_HEAD;
		else if (geom_end && !geom_fail)
			geom_max_head_r <= drive_head_select_r[3:0];
	end

	////////////////////////////////////////////////////////////////
	// Command sequencer

	// Idle, geometry wait, buffer fill, data out
	always_ff @(posedge clk_sys) begin
		if (sys_rst) begin
			state_r <= S_IDLE;
		end else begin
			case (state_r)
				S_IDLE: begin
					if (cmd_geom)
						state_r <= S_GEOM;
					else if (cmd_ident)
						state_r <= S_FILL;
				end
				S_GEOM: begin
					if (geom_end)
						state_r <= S_IDLE;
				end
				S_FILL: begin
					if (fill_end)
						state_r <= S_DATA;
				end
				S_DATA: begin
					if (data_end)
						state_r <= S_IDLE;
				end
				default: state_r <= S_IDLE;
			endcase
		end
	end

	// Busy time for the geometry command
	always_ff @(posedge clk_sys) begin
		if (sys_rst)
			work_cnt_r <= 8'd0;
		else if (cmd_geom)
			work_cnt_r <= 8'(WORK_CYCLES);
		else if (state_r == S_GEOM && work_cnt_r != 8'd0)
			work_cnt_r <= work_cnt_r - 8'd1;
	end

	// Buffer fill index, one word a cycle
	always_ff @(posedge clk_sys) begin
		if (sys_rst)
			fill_idx_r <= 8'd0;
		else if (cmd_ident)
			fill_idx_r <= 8'd0;
		else if (state_r == S_FILL)
			fill_idx_r <= fill_idx_r + 8'd1;
	end

	// Data port index, word 0 first
	always_ff @(posedge clk_sys) begin
		if (sys_rst)
			rd_idx_r <= 8'd0;
		else if (fill_end)
			rd_idx_r <= 8'd0;
		else if (rd_data)
			rd_idx_r <= rd_idx_r + 8'd1;
	end

	////////////////////////////////////////////////////////////////
	// Status, error and interrupt

	always_ff @(posedge clk_sys) begin
		if (sys_rst)
			error_code_r <= ERR_NONE;
		else if (cmd_bad || geom_fail)
			error_code_r <= ERR_ABORTED;
		else if (cmd_any)
			error_code_r <= ERR_NONE;
	end

	always_ff @(posedge clk_sys) begin
		if (sys_rst) begin
			drive_state_r <= RESET_STATE;
		end else begin
			// Error bit follows the error register
			if (cmd_bad || geom_fail)
				drive_state_r[ST_ERROR] <= 1'b1;
			else if (cmd_any)
				drive_state_r[ST_ERROR] <= 1'b0;
			if (cmd_geom)
				drive_state_r[ST_BUSY] <= 1'b1;
			else if (cmd_ident)
				drive_state_r[ST_BUSY] <= 1'b1;
			else if (geom_end || fill_end)
				drive_state_r[ST_BUSY] <= 1'b0;
			// DRQ stands until the last data word
			if (fill_end)
				drive_state_r[ST_DATA_REQ] <= 1'b1;
			else if (data_end)
				drive_state_r[ST_DATA_REQ] <= 1'b0;
		end
	end

	// Set wins over a status read in the same cycle
	always_ff @(posedge clk_sys) begin
		if (sys_rst)
			intrq <= 1'b0;
		else if (cmd_bad || geom_end)
			intrq <= 1'b1;
		else if (fill_end)
			intrq <= 1'b1;
		else if (rd_state || cmd_any)
			intrq <= 1'b0;
	end

	////////////////////////////////////////////////////////////////
	// Sector buffer

	// No cylinder translation: word 54 shows the default count
	identify_rom u_rom (
		.word_idx(fill_idx_r),
		.cur_cylinders(DEF_CYLINDERS),
		.cur_heads(cur_heads),
		.word_val(rom_word)
	);

	always_ff @(posedge clk_sys) begin
		if (state_r == S_FILL)
			id_buf[fill_idx_r] <= rom_word;
	end

	////////////////////////////////////////////////////////////////
	// Read data

	always_comb begin
		rd_mux = 16'h0000;
		case (reg_addr)
			ADDR_DATA: rd_mux = (state_r == S_DATA) ?
				id_buf[rd_idx_r] : 16'h0000;
			ADDR_ERROR_FEATURE: rd_mux = {8'h00, error_code_r};
			ADDR_TRANSFER_COUNT: rd_mux = {8'h00, transfer_count_r};
			ADDR_SECTOR_INDEX: rd_mux = {8'h00, sector_index_r};
			ADDR_CYL_LOW: rd_mux = {8'h00, cylinder_low_byte_r};
			ADDR_CYL_HIGH: rd_mux = {8'h00, cylinder_high_byte_r};
			ADDR_DRIVE_HEAD: rd_mux = {8'h00, drive_head_select_r};
			ADDR_CMD_STATE: rd_mux = {8'h00, drive_state_r};
			default: rd_mux = 16'h0000;
		endcase
	end

	always_ff @(posedge clk_sys) begin
		if (sys_rst)
			data_out_r <= 16'h0000;
		else if (reg_rd)
			data_out_r <= rd_mux;
	end

	assign reg_rdata = data_out_r;
endmodule // geom_id_cmds

// [dv/geom_id_cmds_props.sv]
// Port assertions for geom_id_cmds.
// Assumes the host reads status only once intrq is seen or when idle.
`timescale 1ns/1ps
module geom_id_cmds_props
	import geom_id_pkg::*;
(
	// Clock and reset
	input wire logic clk_sys,
	input wire logic sys_rst,
	input wire logic por_rst,
	// Task file
	input wire logic [9:0] reg_addr,
	input wire logic reg_wr,
	input wire logic reg_rd,
	input wire logic [15:0] reg_wdata,
	input wire logic [15:0] reg_rdata,
	// Select and interrupt
	input wire logic drive_id_pin,
	input wire logic intrq
);
	logic sel_r;
	logic zero_r;
	logic st_rd;
	logic st_wr;
	logic cmd_w;
	default clocking cb @(posedge clk_sys);
	endclocking
	default disable iff (sys_rst);
	always_ff @(posedge clk_sys) begin
		if (sys_rst) begin
			sel_r <= 1'b0;
		end else if (reg_wr && reg_addr == ADDR_DRIVE_HEAD) begin
			sel_r <= reg_wdata[DH_SELECT_BIT];
		end
	end
	always_ff @(posedge clk_sys) begin
		if (sys_rst) begin
			zero_r <= 1'b0;
		end else if (reg_wr && reg_addr == ADDR_TRANSFER_COUNT) begin
			zero_r <= reg_wdata[7:0] == 8'h00;
		end
	end
	assign st_rd = reg_rd && reg_addr == ADDR_CMD_STATE &&
		sel_r == drive_id_pin;
	assign st_wr = reg_wr && reg_addr == ADDR_CMD_STATE;
	assign cmd_w = st_wr && sel_r == drive_id_pin;
	////////////////////////////////////////////////////////////////////
	property p_reset_quiet;
		$fell(sys_rst) |-> !intrq && reg_rdata == 16'h0000;
	endproperty
	a_reset_quiet: assert property (p_reset_quiet)
		else $error("outputs not idle after reset");
	property p_rdata_hold;
		!$past(reg_rd) |-> $stable(reg_rdata);
	endproperty
	a_rdata_hold: assert property (p_rdata_hold)
		else $error("read data moved without a read");
	property p_geom_busy;
		cmd_w && reg_wdata[7:0] == 8'h91 |=> !intrq [*8];
	endproperty
	a_geom_busy: assert property (p_geom_busy)
		else $error("geometry finished too early");
	property p_geom_done;
		cmd_w && reg_wdata[7:0] == 8'h91 && !zero_r |=> ##[9:13] intrq;
	endproperty
	a_geom_done: assert property (p_geom_done)
		else $error("geometry never completed");
	property p_geom_abort;
		cmd_w && reg_wdata[7:0] == 8'h91 && zero_r
			|-> ##1 (!intrq) [*8] ##[1:5] intrq;
	endproperty
	a_geom_abort: assert property (p_geom_abort)
		else $error("zero count geometry not ended");
	property p_ident_done;
		cmd_w && reg_wdata[7:0] == 8'hEC |=> ##[254:258] intrq;
	endproperty
	a_ident_done: assert property (p_ident_done)
		else $error("identify block not offered in time");
	property p_irq_hold;
		intrq && !st_rd && !st_wr |=> intrq;
	endproperty
	a_irq_hold: assert property (p_irq_hold)
		else $error("interrupt dropped unasked");
	property p_irq_clear;
		st_rd |=> !intrq;
	endproperty
	a_irq_clear: assert property (p_irq_clear)
		else $error("status read left interrupt set");
endmodule // geom_id_cmds_props

bind geom_id_cmds geom_id_cmds_props geom_id_cmds_props_inst (
	.clk_sys(clk_sys),
	.sys_rst(sys_rst),
	.por_rst(por_rst),
	.reg_addr(reg_addr),
	.reg_wr(reg_wr),
	.reg_rd(reg_rd),
	.reg_wdata(reg_wdata),
	.reg_rdata(reg_rdata),
	.drive_id_pin(drive_id_pin),
	.intrq(intrq)
);

// [dv/host_model.sv]
// Host adapter model driving the task-file port.
// Strobes are one-cycle pulses; released lines show inverted values.
`timescale 1ns/1ps
module host_model
	import geom_id_pkg::*;
(
	// Clock
	input wire logic clk_sys,
	// Task file
	output logic [9:0] reg_addr,
	output logic reg_wr,
	output logic reg_rd,
	output logic [15:0] reg_wdata,
	input wire logic [15:0] reg_rdata
);
	logic [15:0] blk [0:255];
	initial begin
		reg_addr = 10'h000;
		reg_wr = 1'b0;
		reg_rd = 1'b0;
		reg_wdata = 16'h0000;
	end
	task automatic xfer(input logic wr, input logic [9:0] a,
		input logic [15:0] d, output logic [15:0] q);
		@(posedge clk_sys);
		#1;
		reg_addr = a;
		reg_wdata = d;
		reg_wr = wr;
		reg_rd = !wr;
		@(posedge clk_sys);
		#1;
		q = reg_rdata;
		reg_wr = 1'b0;
		reg_rd = 1'b0;
		reg_addr = ~a;
		reg_wdata = ~d;
	endtask
	// Whole parameter block, word 0 first
	task automatic read_block;
		logic [15:0] d;
		for (int w = 0; w < 256; w++) begin
			xfer(1'b0, ADDR_DATA, 16'h0000, d);
			blk[w] = d;
		end
	endtask
endmodule // host_model

// [dv/tb_top.sv]
// Self-checking bench for the geometry and identify handler.
// Host model drives the task file; results judged at the ports.
`timescale 1ns/1ps
module tb_top;
	import geom_id_pkg::*;
	logic clk_sys;
	logic sys_rst;
	logic por_rst;
	logic drive_id_pin;
	logic [9:0] reg_addr;
	logic reg_wr;
	logic reg_rd;
	logic [15:0] reg_wdata;
	logic [15:0] reg_rdata;
	logic intrq;
	logic [15:0] q;
	int fails;
	int tests_run;
	geom_id_cmds geom_id_cmds_inst (
		.clk_sys(clk_sys),
		.sys_rst(sys_rst),
		.por_rst(por_rst),
		.reg_addr(reg_addr),
		.reg_wr(reg_wr),
		.reg_rd(reg_rd),
		.reg_wdata(reg_wdata),
		.reg_rdata(reg_rdata),
		.drive_id_pin(drive_id_pin),
		.intrq(intrq)
	);
	host_model host_model_inst (
		.clk_sys(clk_sys),
		.reg_addr(reg_addr),
		.reg_wr(reg_wr),
		.reg_rd(reg_rd),
		.reg_wdata(reg_wdata),
		.reg_rdata(reg_rdata)
	);
	initial begin
		clk_sys = 1'b0;
		forever #20 clk_sys = ~clk_sys;
	end
	////////////////////////////////////////////////////////////////////
	task automatic chk(input logic [15:0] got, input logic [15:0] exp);
		tests_run++;
		if (got !== exp) begin
			fails++;
			$display("[ERR] %0t got %h expected %h", $time, got, exp);
		end
	endtask
	task automatic finish_test;
		$display("checks %0d mismatches %0d", tests_run, fails);
		if (fails == 0 && tests_run > 0) begin
			$display("SIMULATION PASSED");
		end else begin
			$display("SIMULATION FAILED");
		end
		$finish;
	endtask
	task automatic wr(input logic [9:0] a, input logic [15:0] d);
		host_model_inst.xfer(1'b1, a, d, q);
	endtask
	task automatic rd(input logic [9:0] a, input logic [15:0] exp);
		host_model_inst.xfer(1'b0, a, 16'h0000, q);
		chk(q, exp);
	endtask
	task automatic wait_irq(input int lim);
		for (int n = 0; n < lim && intrq !== 1'b1; n++) begin
			@(posedge clk_sys);
			#1;
		end
		if (intrq !== 1'b1) begin
			chk({15'h0000, intrq}, 16'h0001);
			finish_test();
		end
	endtask
	task automatic pulse(input logic sys, input logic por);
		sys_rst = sys;
		por_rst = por;
		repeat (4) @(posedge clk_sys);
		#1;
		sys_rst = 1'b0;
		por_rst = 1'b0;
	endtask
	function automatic logic [15:0] id_word(input int w,
		input logic [15:0] hd);
		case (w)
			0: return 16'h045A;
			1, 54: return 16'h3FFF;
			3: return 16'h0010;
			6: return 16'h003F;
			20: return 16'h0000;
			21: return 16'h1000;
			22: return 16'h0004;
			47: return 16'h8010;
			49: return 16'h0B00;
			51: return 16'h0200;
			53: return 16'h0007;
			55: return hd;
			default: return (w inside {[10:46]}) ? 16'h2020 : 16'h0000;
		endcase
	endfunction
	////////////////////////////////////////////////////////////////////
	task automatic t_ident(input logic [15:0] hd);
		wr(ADDR_CMD_STATE, 16'h00EC);
		wait_irq(300);
		rd(ADDR_CMD_STATE, 16'h0058);
		host_model_inst.read_block();
		for (int w = 0; w < 256; w++) begin
			chk(host_model_inst.blk[w], id_word(w, hd));
		end
		rd(ADDR_CMD_STATE, 16'h0050);
		rd(ADDR_DATA, 16'h0000);
	endtask
	task automatic t_geom(input logic [7:0] n, input logic [3:0] mh,
		input logic [3:0] hi);
		wr(ADDR_TRANSFER_COUNT, {8'h00, n});
		wr(ADDR_DRIVE_HEAD, {8'h00, hi, mh});
		wr(ADDR_CMD_STATE, 16'h0091);
		wait_irq(20);
		rd(ADDR_CMD_STATE, (n == 8'h00) ? 16'h0051 : 16'h0050);
		rd(ADDR_ERROR_FEATURE, (n == 8'h00) ? 16'h0004 : 16'h0000);
	endtask
	task automatic t_odd;
		// Other drive addressed, then an unhandled code
		wr(ADDR_DRIVE_HEAD, 16'h0010);
		wr(ADDR_CMD_STATE, 16'h0091);
		repeat (20) @(posedge clk_sys);
		chk({15'h0000, intrq}, 16'h0000);
		wr(ADDR_DRIVE_HEAD, 16'h0000);
		wr(ADDR_CMD_STATE, 16'h0020);
		wait_irq(40);
		rd(ADDR_CMD_STATE, 16'h0051);
		rd(ADDR_ERROR_FEATURE, 16'h0004);
	endtask
	////////////////////////////////////////////////////////////////////
	initial begin
		fails = 0;
		tests_run = 0;
		drive_id_pin = 1'b0;
		sys_rst = 1'b1;
		por_rst = 1'b1;
		pulse(1'b1, 1'b1);
		rd(ADDR_CMD_STATE, 16'h0050);
		rd(ADDR_TRANSFER_COUNT, 16'h0001);
		rd(ADDR_SECTOR_INDEX, 16'h0001);
		rd(ADDR_CYL_HIGH, 16'h0000);
		rd(ADDR_ERROR_FEATURE, 16'h0000);
		t_ident(16'h0010);
		t_odd();
		t_geom(8'h11, 4'h7, 4'h0);
		t_geom(8'h00, 4'h3, 4'h0);
		t_ident(16'h0008);
		pulse(1'b1, 1'b0);
		t_ident(16'h0008);
		drive_id_pin = 1'b1;
		t_geom(8'h3F, 4'h3, 4'h5);
		t_ident(16'h0004);
		pulse(1'b0, 1'b1);
		t_ident(16'h0010);
		finish_test();
	end
endmodule // tb_top
